// ### verilog/ues_pkg.sv
/*
  Constants for one USB endpoint's control/status and byte FIFO port:
  APB offsets, field positions, reset values, endpoint type codes.
  Assumes a 32-bit APB slave on a single 125 MHz clock.
*/
package ues_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  CSR_OFS   = 8'h00;
  localparam logic [7:0]  FIFO_OFS  = 8'h04;
  localparam logic [7:0]  CFG_OFS   = 8'h08;

  // ==========================================================
  // control/status and config field positions, FIFO data width
  localparam int BK0_BIT   = 1;
  localparam int SETUP_BIT = 2;
  localparam int TXRDY_BIT = 4;
  localparam int BK1_BIT   = 6;
  localparam int DIR_BIT   = 7;
  localparam int TYPE_LSB  = 8;
  localparam int TYPE_W    = 3;
  localparam int DTGL_BIT  = 11;
  localparam int EN_BIT    = 15;
  localparam int CNT_LSB   = 16;
  localparam int CNT_W     = 11;
  localparam int DUAL_BIT  = 0;
  localparam int DATA_W    = 8;

  // ==========================================================
  // endpoint type codes; bit 2 marks the IN direction
  localparam logic [2:0] TYPE_CTRL   = 3'h0;
  localparam logic [2:0] TYPE_ISO_O  = 3'h1;
  localparam logic [2:0] TYPE_ISO_I  = 3'h5;
  localparam logic [2:0] TYPE_BLK_O  = 3'h2;
  localparam logic [2:0] TYPE_BLK_I  = 3'h6;
  localparam logic [2:0] TYPE_INT_O  = 3'h3;
  localparam logic [2:0] TYPE_INT_I  = 3'h7;
  localparam int         TYPE_IN_BIT = 2;

  // ==========================================================
  // values after reset and buffer sizing
  localparam logic [2:0]        TYPE_RST   = 3'h0;
  localparam logic [CNT_W-1:0]  CNT_RST    = 11'h000;
  localparam logic [31:0]       RDATA_RST  = 32'h0000_0000;
  localparam int                FIFO_DEPTH = 4;

endpackage

// ### verilog/ues_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module ues_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [CNT_W-1:0]            count;
  } uesFifoState_t;

  uesFifoState_t st;
  uesFifoState_t next_st;
  logic          push;
  logic          pop;

  // =====================================================
  // handshakes: full and empty come straight from the count
  assign inReady  = (st.count != CNT_W'(DEPTH));
  assign outValid = (st.count != '0);
  assign outData  = st.mem[st.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointer and count update, one entry per transfer
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = (st.wrPtr == PTR_W'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = (st.rdPtr == PTR_W'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### verilog/ues_endpoint.sv
/*
  One USB endpoint: control/status fields, FIFO byte port, receive
  banks and the accept decisions handed to the serial engine.
  Assumes an APB master on clk and a serial engine on the same clock
  that only ends a packet (rxEnd) after outAccept allowed it.
*/
`timescale 1ns/10ps
module ues_endpoint #(
  parameter int DEPTH = ues_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  // apb slave
  input  wire logic [ues_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // receive side from the serial engine
  input  wire logic                       rxIsSetup,
  output logic                            outAccept,
  input  wire logic                       rxValid,
  output logic                            rxReady,
  input  wire logic [7:0]                 rxData,
  input  wire logic                       rxEnd,
  input  wire logic                       rxPid,
  // transmit side to the serial engine
  output logic                            inAccept,
  output logic                            inZeroLen,
  output logic                            txValid,
  input  wire logic                       txReady,
  output logic      [7:0]                 txData,
  input  wire logic                       txDone,
  // level request while a bank or setup packet waits
  output logic                            epIrq
);

  typedef struct packed {
    logic                       bank0Full;
    logic                       bank1Full;
    logic                       setupPend;
    logic                       txPayloadRdy;
    logic                       ctrlDir;
    logic [2:0]                 endpoint_type_code;
    logic                       dataToggle;
    logic                       epEnable;
    logic                       dualBank;
    logic [ues_pkg::CNT_W-1:0]  cnt0;
    logic [ues_pkg::CNT_W-1:0]  cnt1;
    logic [ues_pkg::CNT_W-1:0]  pktLen;
    logic [31:0]                rdata;
  } uesEpState_t;

  uesEpState_t st;
  uesEpState_t next_st;

  logic                      isCtrl;
  logic                      isIn;
  logic                      bankFree;
  logic                      hitCsr;
  logic                      hitFifo;
  logic                      hitCfg;
  logic                      mapped;
  logic                      setupPh;
  logic                      accessDone;
  logic                      csrWr;
  logic                      cfgWr;
  logic                      fifoWr;
  logic                      fifoRd;
  logic                      rxPush;
  logic                      rxOutValid;
  logic [7:0]                rxOutData;
  logic                      rxInReady;
  logic                      txInReady;
  logic                      txOutValid;
  logic                      txSend;
  logic [ues_pkg::CNT_W-1:0] shownCnt;
  logic [31:0]               csrView;

  // =====================================================
  // endpoint kind decode
  assign isCtrl   = (st.endpoint_type_code == ues_pkg::TYPE_CTRL);
  assign isIn     = st.endpoint_type_code[ues_pkg::TYPE_IN_BIT];
  // second bank counts as room only with ping-pong enabled
  assign bankFree = !st.bank0Full || (st.dualBank && !st.bank1Full);

  // =====================================================
  // accept decisions for the serial engine
  // setup taken on control while enabled with bank room; OUT data blocked while setup waits;
  // on control with direction 1 an OUT is the status stage and is taken
  assign outAccept = st.epEnable && bankFree &&
                     (rxIsSetup ? isCtrl
                                : (!st.setupPend && (isCtrl || !isIn)));
  // control with direction 0 answers IN with a zero-length status packet
  assign inZeroLen = isCtrl && !st.ctrlDir;
  assign inAccept  = st.epEnable && !st.setupPend &&
                     (isCtrl ? (!st.ctrlDir || st.txPayloadRdy)
                             : (isIn && st.txPayloadRdy));
  assign txSend    = inAccept && !inZeroLen;
  assign txValid   = txOutValid && txSend;
  assign rxReady   = rxInReady && outAccept;
  assign rxPush    = rxValid && rxReady;
  assign epIrq     = st.bank0Full || st.bank1Full || st.setupPend;

  // =====================================================
  // apb decode; a FIFO write waits while the transmit FIFO is full
  assign hitCsr     = (paddr == ues_pkg::CSR_OFS);
  assign hitFifo    = (paddr == ues_pkg::FIFO_OFS);
  assign hitCfg     = (paddr == ues_pkg::CFG_OFS);
  assign mapped     = hitCsr || hitFifo || hitCfg;
  assign setupPh    = psel && !penable;
  assign pready     = !(psel && penable && pwrite && hitFifo && !txInReady);
  assign pslverr    = psel && penable && !mapped;
  assign accessDone = psel && penable && pready;
  assign csrWr      = accessDone && pwrite && hitCsr;
  assign cfgWr      = accessDone && pwrite && hitCfg;
  assign fifoWr     = accessDone && pwrite && hitFifo;
  assign fifoRd     = accessDone && !pwrite && hitFifo;
  assign prdata     = st.rdata;

  // byte count of the bank firmware is draining
  assign shownCnt = (st.bank1Full && !st.bank0Full) ? st.cnt1 : st.cnt0;

  // =====================================================
  // control/status word as software sees it
  always_comb begin
    csrView = '0;
    csrView[ues_pkg::BK0_BIT]   = st.bank0Full;
    csrView[ues_pkg::SETUP_BIT] = st.setupPend;
    csrView[ues_pkg::TXRDY_BIT] = st.txPayloadRdy;
    csrView[ues_pkg::BK1_BIT]   = st.bank1Full;
    csrView[ues_pkg::DIR_BIT]   = st.ctrlDir;
    csrView[ues_pkg::TYPE_LSB +: ues_pkg::TYPE_W] = st.endpoint_type_code;
    csrView[ues_pkg::DTGL_BIT]  = st.dataToggle;
    csrView[ues_pkg::EN_BIT]    = st.epEnable;
    csrView[ues_pkg::CNT_LSB +: ues_pkg::CNT_W] = shownCnt;
  end

  // =====================================================
  // next state: software writes first, hardware events override except a TXRDY set by a write in the txDone cycle
  always_comb begin
    next_st = st;

    // read data latched in the setup cycle, stable through access
    if (setupPh) begin
      if (hitCsr) begin
        next_st.rdata = csrView;
      end else if (hitCfg) begin
        next_st.rdata = {31'h0000_0000, st.dualBank};
      end else if (hitFifo) begin
        next_st.rdata = {24'h00_0000, (rxOutValid ? rxOutData : 8'h00)};
      end else begin
        next_st.rdata = ues_pkg::RDATA_RST;
      end
    end

    // software writes to the control/status word
    if (csrWr) begin
      if (!pwdata[ues_pkg::BK0_BIT]) begin
        next_st.bank0Full = 1'b0;
      end
      if (!pwdata[ues_pkg::BK1_BIT]) begin
        next_st.bank1Full = 1'b0;
      end
      if (!pwdata[ues_pkg::SETUP_BIT]) begin
        next_st.setupPend = 1'b0;
      end
      if (pwdata[ues_pkg::TXRDY_BIT]) begin
        next_st.txPayloadRdy = 1'b1;
      end
      next_st.ctrlDir  = pwdata[ues_pkg::DIR_BIT];
      next_st.endpoint_type_code   = pwdata[ues_pkg::TYPE_LSB +: ues_pkg::TYPE_W];
      next_st.epEnable = pwdata[ues_pkg::EN_BIT];
    end
    if (cfgWr) begin
      next_st.dualBank = pwdata[ues_pkg::DUAL_BIT];
    end

    // each byte popped lowers the count of the bank being drained, which holds at zero
    if (fifoRd && rxOutValid && (shownCnt != '0)) begin
      if (st.bank1Full && !st.bank0Full) begin
        next_st.cnt1 = st.cnt1 - 1'b1;
      end else begin
        next_st.cnt0 = st.cnt0 - 1'b1;
      end
    end

    // bytes of the packet in flight
    if (rxPush) begin
      next_st.pktLen = st.pktLen + 1'b1;
    end

    // end of a received packet: pick a bank, latch length and toggle
    if (rxEnd) begin
      next_st.pktLen     = '0;
      next_st.dataToggle = rxPid;
      if (rxIsSetup) begin
        next_st.setupPend = 1'b1;
        next_st.cnt0      = st.pktLen;
      end else if (!st.bank0Full) begin
        next_st.bank0Full = 1'b1;
        next_st.cnt0      = st.pktLen;
      end else if (st.dualBank && !st.bank1Full) begin
        next_st.bank1Full = 1'b1;
        next_st.cnt1      = st.pktLen;
      end
    end

    // acknowledged IN: payload consumed, toggle advances
    if (txDone) begin
      next_st.dataToggle = !st.dataToggle;
      if (!(csrWr && pwdata[ues_pkg::TXRDY_BIT])) begin
        next_st.txPayloadRdy = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st        <= '0;
      st.endpoint_type_code <= ues_pkg::TYPE_RST;
      st.cnt0   <= ues_pkg::CNT_RST;
      st.cnt1   <= ues_pkg::CNT_RST;
      st.rdata  <= ues_pkg::RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================
  // receive path: engine fills, firmware drains one byte per read
  ues_fifo #(
    .WIDTH (ues_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (rxPush),
    .inReady  (rxInReady),
    .inData   (rxData),
    .outValid (rxOutValid),
    .outReady (fifoRd),
    .outData  (rxOutData)
  );

  // transmit path: firmware fills, engine drains during IN data
  ues_fifo #(
    .WIDTH (ues_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (fifoWr),
    .inReady  (txInReady),
    .inData   (pwdata[7:0]),
    .outValid (txOutValid),
    .outReady (txReady && txSend),
    .outData  (txData)
  );

endmodule

// ### dv/ues_endpoint_properties.sv
/*
  Port checks for ues_endpoint, bound from the bench.
  Assumes one clock and srst synchronous, active high.
*/
`timescale 1ns/10ps
module ues_endpoint_properties (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        rxIsSetup,
  input wire logic        outAccept,
  input wire logic        rxReady,
  input wire logic        rxEnd,
  input wire logic        inAccept,
  input wire logic        inZeroLen,
  input wire logic        txValid,
  input wire logic        epIrq
);
  logic csrWr;

  // ==========================================
  // completed firmware write of control/status
  assign csrWr = psel && penable && pready && pwrite && (paddr == ues_pkg::CSR_OFS);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ==========================================
  // flags, gating and bus answers
  AST_RX_FLAG: assert property (rxEnd |=> epIrq) else $error("no request after packet");
  AST_IRQ_HOLD: assert property (epIrq && !csrWr |=> epIrq) else $error("request dropped");
  AST_RX_GATE: assert property (rxReady |-> outAccept) else $error("byte taken unaccepted");
  AST_TX_GATE: assert property (txValid |-> inAccept && !inZeroLen)
    else $error("byte sent without IN");
  AST_APB_READY: assert property (psel && penable && !(pwrite && paddr == ues_pkg::FIFO_OFS)
    |-> pready) else $error("wait state on plain access");
  AST_DISABLE: assert property (csrWr && !pwdata[ues_pkg::EN_BIT]
    |=> !outAccept && !inAccept) else $error("disabled endpoint accepts");
  AST_SETUP_BLOCK: assert property (rxEnd && rxIsSetup ##1 !rxIsSetup |-> !outAccept)
    else $error("OUT accepted while setup pending");
  AST_IN_TYPE: assert property (csrWr && pwdata[ues_pkg::TYPE_LSB + ues_pkg::TYPE_IN_BIT]
    |=> !outAccept) else $error("OUT accepted on IN type");
endmodule

// ### dv/ues_host_model.sv
/*
  Serial engine model on the host side: sends OUT and SETUP packets, takes IN bytes.
  Assumes the endpoint on the same clock; tasks are entered right after an edge.
*/
`timescale 1ns/10ps
module ues_host_model (
  input  wire logic       clk,
  input  wire logic       rxReady,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            rxIsSetup,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxEnd,
  output logic            rxPid,
  output logic            txReady,
  output logic            txDone
);
  logic [7:0] txSeen[$];

  // idle levels
  initial begin
    rxIsSetup = 1'b0;
    rxValid = 1'b0;
    rxData = 8'hA5;
    rxEnd = 1'b0;
    rxPid = 1'b0;
    txReady = 1'b0;
    txDone = 1'b0;
  end

  // one packet of n bytes counting up from first, then the end pulse
  task automatic send(input int n, input logic setup, input logic pid, input logic [7:0] first);
    int k;
    rxIsSetup <= setup;
    rxPid <= pid;
    for (k = 0; k < n; k++) begin
      rxValid <= 1'b1;
      rxData <= first + 8'(k);
      do @(posedge clk); while (!rxReady);
    end
    rxValid <= 1'b0;
    rxData <= ~rxData; // released line shows no stale byte
    rxEnd <= 1'b1;
    @(posedge clk);
    rxEnd <= 1'b0;
    rxIsSetup <= 1'b0;
    @(posedge clk); // idle edge: flags settled, no double drive
  endtask

  // takes n IN bytes, stalling every other cycle, then acknowledges
  task automatic fetch(input int n);
    int got;
    got = 0;
    while (got < n) begin
      txReady <= ~txReady;
      @(posedge clk);
      if (txValid && txReady) begin
        txSeen.push_back(txData);
        got++;
      end
    end
    txReady <= 1'b0;
    txDone <= 1'b1;
    @(posedge clk);
    txDone <= 1'b0;
  endtask
endmodule

// ### dv/ues_endpoint_bench.sv
/*
  Self-checking bench for ues_endpoint: APB firmware traffic with random data.
  Assumes ues_pkg, the design files, the host model and the checker compiled first.
*/
`timescale 1ns/10ps
module ues_endpoint_bench;
  localparam logic [31:0] B0 = 32'h1 << ues_pkg::BK0_BIT;
  localparam logic [31:0] SU = 32'h1 << ues_pkg::SETUP_BIT;
  localparam logic [31:0] TR = 32'h1 << ues_pkg::TXRDY_BIT;
  localparam logic [31:0] B1 = 32'h1 << ues_pkg::BK1_BIT;
  localparam logic [31:0] DR = 32'h1 << ues_pkg::DIR_BIT;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err, pid;
  logic [7:0]  paddr, rxData, txData;
  logic [31:0] pwdata, prdata, rd;
  logic        rxIsSetup, outAccept, rxValid, rxReady, rxEnd, rxPid;
  logic        inAccept, inZeroLen, txValid, txReady, txDone, epIrq;
  logic [7:0]  tb[2];
  int          failures, num_checks, seed, cycles, n0, n1, i;

  ues_endpoint i_ues_endpoint (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxIsSetup(rxIsSetup), .outAccept(outAccept), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .rxEnd(rxEnd), .rxPid(rxPid), .inAccept(inAccept),
    .inZeroLen(inZeroLen), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txDone(txDone), .epIrq(epIrq));
  ues_host_model i_ues_host_model (.clk(clk), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .rxIsSetup(rxIsSetup), .rxValid(rxValid), .rxData(rxData),
    .rxEnd(rxEnd), .rxPid(rxPid), .txReady(txReady), .txDone(txDone));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [31:0] csr(input logic [31:0] f, input logic [2:0] ty,
                                      input logic tg, input logic en, input logic [10:0] n);
    return f | (32'(ty) << ues_pkg::TYPE_LSB) | (32'(tg) << ues_pkg::DTGL_BIT)
      | (32'(en) << ues_pkg::EN_BIT) | (32'(n) << ues_pkg::CNT_LSB);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer, held until pready, then released for one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 57448;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, ues_pkg::RDATA_RST);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // every type code except 4; toggle and count ignore writes
    for (i = 0; i < 8; i++) begin
      if (i != 4) begin
        apb(1'b1, ues_pkg::CSR_OFS, csr(32'h0, 3'(i), 1'b1, i[0], 11'h7FF));
        apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
        check(rd, csr(32'h0, 3'(i), 1'b0, i[0], 11'h000));
      end
    end
    // two OUT packets into both banks
    n0 = 1 + ($unsigned($random(seed)) % 2);
    n1 = 1 + ($unsigned($random(seed)) % 2);
    pid = 1'($random(seed));
    apb(1'b1, ues_pkg::CFG_OFS, 32'h1);
    apb(1'b0, ues_pkg::CFG_OFS, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, ues_pkg::CSR_OFS, csr(32'h0, ues_pkg::TYPE_BLK_O, 1'b0, 1'b1, 11'h000));
    i_ues_host_model.send(n0, 1'b0, pid, 8'h10);
    i_ues_host_model.send(n1, 1'b0, ~pid, 8'h20);
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(B0 | B1, ues_pkg::TYPE_BLK_O, ~pid, 1'b1, 11'(n0)));
    check({31'h0, epIrq}, 32'h1);
    for (i = 0; i < n0; i++) begin
      apb(1'b0, ues_pkg::FIFO_OFS, 32'h0);
      check(rd, 32'h10 + i);
    end
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(B0 | B1, ues_pkg::TYPE_BLK_O, ~pid, 1'b1, 11'h000));
    apb(1'b1, ues_pkg::CSR_OFS, csr(B1, ues_pkg::TYPE_BLK_O, 1'b0, 1'b1, 11'h000));
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(B1, ues_pkg::TYPE_BLK_O, ~pid, 1'b1, 11'(n1)));
    for (i = 0; i < n1; i++) begin
      apb(1'b0, ues_pkg::FIFO_OFS, 32'h0);
      check(rd, 32'h20 + i);
    end
    apb(1'b1, ues_pkg::CSR_OFS, csr(32'h0, ues_pkg::TYPE_BLK_O, 1'b0, 1'b1, 11'h000));
    apb(1'b1, ues_pkg::CSR_OFS, csr(B1, ues_pkg::TYPE_BLK_O, 1'b0, 1'b1, 11'h000));
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(32'h0, ues_pkg::TYPE_BLK_O, ~pid, 1'b1, 11'h000));
    check({31'h0, epIrq}, 32'h0);
    // single bank: after one packet, further OUT refused
    apb(1'b1, ues_pkg::CFG_OFS, 32'h0);
    apb(1'b0, ues_pkg::CFG_OFS, 32'h0);
    check(rd, 32'h0);
    i_ues_host_model.send(1, 1'b0, 1'b0, 8'h40);
    check({31'h0, outAccept}, 32'h0);
    apb(1'b0, ues_pkg::FIFO_OFS, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, ues_pkg::FIFO_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, ues_pkg::CSR_OFS, csr(32'h0, ues_pkg::TYPE_CTRL, 1'b0, 1'b1, 11'h000));
    // setup, IN data stage, status stage
    i_ues_host_model.send(2, 1'b1, 1'b0, 8'h30);
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(SU, ues_pkg::TYPE_CTRL, 1'b0, 1'b1, 11'h002));
    check({31'h0, outAccept}, 32'h0);
    for (i = 0; i < 2; i++) begin
      apb(1'b0, ues_pkg::FIFO_OFS, 32'h0);
      check(rd, 32'h30 + i);
      tb[i] = 8'($random(seed));
      apb(1'b1, ues_pkg::FIFO_OFS, {24'h0, tb[i]});
    end
    apb(1'b1, ues_pkg::CSR_OFS, csr(DR | TR, ues_pkg::TYPE_CTRL, 1'b0, 1'b1, 11'h000));
    check({30'h0, inAccept, inZeroLen}, 32'h2);
    i_ues_host_model.fetch(2);
    for (i = 0; i < 2; i++) begin
      check({24'h0, i_ues_host_model.txSeen[i]}, {24'h0, tb[i]});
    end
    apb(1'b0, ues_pkg::CSR_OFS, 32'h0);
    check(rd, csr(DR, ues_pkg::TYPE_CTRL, 1'b1, 1'b1, 11'h000));
    check({31'h0, outAccept}, 32'h1);
    apb(1'b1, ues_pkg::CSR_OFS, csr(32'h0, ues_pkg::TYPE_CTRL, 1'b0, 1'b1, 11'h000));
    check({30'h0, outAccept, inZeroLen}, 32'h3);
    complete_run();
  end
endmodule

bind ues_endpoint ues_endpoint_properties i_ues_endpoint_properties (
  .clk       (clk),
  .srst      (srst),
  .paddr     (paddr),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .pwdata    (pwdata),
  .pready    (pready),
  .rxIsSetup (rxIsSetup),
  .outAccept (outAccept),
  .rxReady   (rxReady),
  .rxEnd     (rxEnd),
  .inAccept  (inAccept),
  .inZeroLen (inZeroLen),
  .txValid   (txValid),
  .epIrq     (epIrq)
);
